/* File: core/positioning_option_decoder.sv */
// Purpose: Holds the positioning option word and drives the setpoint handshake and move plan.
// Assumes: Motion core inputs are synchronous to aclk; host uses AXI4-Lite.
// Notes: A bus write that sets the new-setpoint bit wins over a hardware release in that cycle.
//
// Added by the designer: register access over AXI4-Lite.
module positioning_option_decoder (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Motion core inputs
  input wire logic profile_position_mode,
  input wire logic target_reached,
  input wire logic [31:0] ramp_output,
  input wire logic [31:0] actual_position,
  input wire logic [31:0] following_error_in,
  // Move plan outputs
  output logic move_start,
  output posopt_pkg::move_plan_t move_plan,
  output logic setpoint_ack
);

  typedef enum logic [2:0] {ST_IDLE, ST_HOST_HS, ST_WAIT_REACH, ST_RELEASE, ST_CLEAR_ACK} release_state_t;

  release_state_t state_ff;
  release_state_t nxt_state;
  logic [15:0] positioning_options_ff;
  logic [31:0] following_error_value_ff;
  logic [15:0] control_ff;
  logic [31:0] target_ff;
  logic [31:0] range_min_ff;
  logic [31:0] range_max_ff;
  logic [31:0] prev_target_ff;
  logic has_prev_ff;
  logic ack_ff;
  logic start_ff;
  posopt_pkg::move_plan_t plan_ff;
  logic [31:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  posopt_pkg::option_fields_t opts;
  posopt_pkg::position_inputs_t pos;
  posopt_pkg::move_plan_t plan_calc;
  logic do_write;
  logic ctrl_wr;
  logic ctrl_wr_sets;
  logic [31:0] ctrl_wdata;
  logic accept;
  logic hw_release;
  logic [31:0] nxt_rdata;
  logic nxt_rerr;

  assign opts = posopt_pkg::decode_options(positioning_options_ff);
  assign pos = '{ramp_output: ramp_output, actual_position: actual_position,
                 prev_target: prev_target_ff, has_prev_target: has_prev_ff};

  move_planner u_planner (
    .target_in(target_ff),
    .relative(control_ff[posopt_pkg::CTRL_RELATIVE]),
    .opts(opts),
    .pos(pos),
    .range_min(range_min_ff),
    .range_max(range_max_ff),
    .plan(plan_calc)
  );

  // Write channel: address and data are taken in either order, then answered together.
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 32'h00000000;
    end else if (s_axi_awvalid && !aw_held_ff) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && !w_held_ff) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= posopt_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      unique case (awaddr_ff)
        posopt_pkg::ADDR_OPTIONS, posopt_pkg::ADDR_CONTROL, posopt_pkg::ADDR_TARGET,
        posopt_pkg::ADDR_RANGE_MIN, posopt_pkg::ADDR_RANGE_MAX: bresp_ff <= posopt_pkg::RESP_OKAY;
        default: bresp_ff <= posopt_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Option word and configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      positioning_options_ff <= posopt_pkg::OPTIONS_RESET;
    end else if (do_write && awaddr_ff == posopt_pkg::ADDR_OPTIONS) begin
      positioning_options_ff <= 16'(posopt_pkg::merge_strb({16'h0000, positioning_options_ff},
                                                             wdata_ff, wstrb_ff));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_ff <= posopt_pkg::TARGET_RESET;
      range_min_ff <= posopt_pkg::RANGE_MIN_RESET;
      range_max_ff <= posopt_pkg::RANGE_MAX_RESET;
    end else if (do_write) begin
      if (awaddr_ff == posopt_pkg::ADDR_TARGET) begin
        target_ff <= posopt_pkg::merge_strb(target_ff, wdata_ff, wstrb_ff);
      end
      if (awaddr_ff == posopt_pkg::ADDR_RANGE_MIN) begin
        range_min_ff <= posopt_pkg::merge_strb(range_min_ff, wdata_ff, wstrb_ff);
      end
      if (awaddr_ff == posopt_pkg::ADDR_RANGE_MAX) begin
        range_max_ff <= posopt_pkg::merge_strb(range_max_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  // Control word: host writes, hardware releases the new-setpoint bit.
  assign ctrl_wr = do_write && awaddr_ff == posopt_pkg::ADDR_CONTROL;
  assign ctrl_wdata = posopt_pkg::merge_strb({16'h0000, control_ff}, wdata_ff, wstrb_ff);
  assign ctrl_wr_sets = ctrl_wr && ctrl_wdata[posopt_pkg::CTRL_NEW_SETPOINT];
  assign hw_release = state_ff == ST_RELEASE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_ff <= posopt_pkg::CONTROL_RESET;
    end else if (ctrl_wr) begin
      control_ff <= ctrl_wdata[15:0];
    end else if (hw_release) begin
      control_ff[posopt_pkg::CTRL_NEW_SETPOINT] <= 1'b0;
    end
  end

  // Setpoint release sequence.
  assign accept = profile_position_mode && control_ff[posopt_pkg::CTRL_NEW_SETPOINT]
                  && state_ff == ST_IDLE && !ack_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          unique case (opts.release_sel)
            posopt_pkg::REL_AT_ONCE: nxt_state = ST_RELEASE;
            posopt_pkg::REL_ON_REACH: nxt_state = ST_WAIT_REACH;
            default: nxt_state = ST_HOST_HS;
          endcase
        end
      end
      ST_WAIT_REACH: begin
        if (target_reached) begin
          nxt_state = ST_RELEASE;
        end
      end
      ST_RELEASE: nxt_state = ST_CLEAR_ACK;
      ST_CLEAR_ACK: nxt_state = ST_IDLE;
      ST_HOST_HS: begin
        if (!control_ff[posopt_pkg::CTRL_NEW_SETPOINT]) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_ff <= 1'b0;
    end else if (accept) begin
      ack_ff <= 1'b1;
    end else if (state_ff == ST_CLEAR_ACK) begin
      ack_ff <= 1'b0;
    end else if (state_ff == ST_HOST_HS && !control_ff[posopt_pkg::CTRL_NEW_SETPOINT]) begin
      ack_ff <= 1'b0;
    end
  end

  // Move plan is latched when a setpoint is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      plan_ff <= '0;
      start_ff <= 1'b0;
      prev_target_ff <= 32'h00000000;
      has_prev_ff <= 1'b0;
    end else begin
      start_ff <= accept;
      if (accept) begin
        plan_ff <= plan_calc;
        prev_target_ff <= plan_calc.target;
        has_prev_ff <= 1'b1;
      end
    end
  end

  // Following error is sampled every cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      following_error_value_ff <= posopt_pkg::FOLLOW_ERR_RESET;
    end else begin
      following_error_value_ff <= following_error_in;
    end
  end

  assign move_start = start_ff;
  assign move_plan = plan_ff;
  assign setpoint_ack = ack_ff;

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_rerr = 1'b0;
    unique case (s_axi_araddr)
      posopt_pkg::ADDR_OPTIONS: nxt_rdata = {16'h0000, positioning_options_ff};
      posopt_pkg::ADDR_FOLLOW_ERR: nxt_rdata = following_error_value_ff;
      posopt_pkg::ADDR_CONTROL: nxt_rdata = {16'h0000, control_ff};
      posopt_pkg::ADDR_STATUS: nxt_rdata = 32'(ack_ff) << posopt_pkg::STAT_SETPOINT_ACK;
      posopt_pkg::ADDR_TARGET: nxt_rdata = target_ff;
      posopt_pkg::ADDR_RANGE_MIN: nxt_rdata = range_min_ff;
      posopt_pkg::ADDR_RANGE_MAX: nxt_rdata = range_max_ff;
      posopt_pkg::ADDR_PLAN_TARGET: nxt_rdata = plan_ff.target;
      posopt_pkg::ADDR_PLAN_FLAGS: nxt_rdata = {29'h00000000, plan_ff.dir_positive, plan_ff.via_limit,
                                                plan_ff.wrapped};
      default: nxt_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= posopt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rerr ? posopt_pkg::RESP_SLVERR : posopt_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  option_reset_a: assert property (@(posedge aclk) !aresetn |=> positioning_options_ff == 16'h0001)
    else $error("Option word not at reset value.");

  ack_on_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    accept |=> ack_ff && move_start)
    else $error("Setpoint taken without acknowledge and start.");

  release_then_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_RELEASE && !ctrl_wr_sets) |=> !control_ff[posopt_pkg::CTRL_NEW_SETPOINT] ##1 !ack_ff)
    else $error("Release did not clear setpoint bit then acknowledge.");

  fast_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (accept && opts.release_sel == posopt_pkg::REL_AT_ONCE) |=> state_ff == ST_RELEASE)
    else $error("Immediate release not started.");

  wait_reach_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_WAIT_REACH && !target_reached) |=> state_ff == ST_WAIT_REACH && ack_ff)
    else $error("Released before target reached.");

  host_hs_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_HOST_HS && control_ff[posopt_pkg::CTRL_NEW_SETPOINT]) |=> ack_ff)
    else $error("Acknowledge dropped during host handshake.");

  ramp_base_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (accept && control_ff[posopt_pkg::CTRL_RELATIVE] && opts.base == posopt_pkg::BASE_RAMP
     && opts.rotary != posopt_pkg::ROT_LINEAR)
    |=> move_plan.target == $past(ramp_output) + $past(target_ff))
    else $error("Relative move not based on ramp output.");

  actual_base_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (accept && control_ff[posopt_pkg::CTRL_RELATIVE] && opts.base == posopt_pkg::BASE_ACTUAL
     && opts.rotary != posopt_pkg::ROT_LINEAR)
    |=> move_plan.target == $past(actual_position) + $past(target_ff))
    else $error("Relative move not based on actual position.");

  neg_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (accept && opts.rotary == posopt_pkg::ROT_NEG_ONLY) |=> !move_plan.dir_positive)
    else $error("Negative-only axis moving positive.");

  pos_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (accept && opts.rotary == posopt_pkg::ROT_POS_ONLY) |=> move_plan.dir_positive)
    else $error("Positive-only axis moving negative.");

  follow_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> following_error_value_ff == $past(following_error_in))
    else $error("Following error not tracking input.");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("Write not answered.");

endmodule

/* File: include/posopt_pkg.sv */
// Purpose: Constants, field layouts and carrier types of the positioning option decoder.
// Assumes: AXI4-Lite with 32-bit data; one aligned word per register.
// Notes: Object indices count words, not bytes, so their byte address is four times the index.
package posopt_pkg;

  localparam logic [31:0] IDX_OPTIONS = 32'h000060F2;
  localparam logic [31:0] IDX_FOLLOW_ERR = 32'h000060F4;
  localparam logic [31:0] ADDR_OPTIONS = IDX_OPTIONS * 32'h00000004;
  localparam logic [31:0] ADDR_FOLLOW_ERR = IDX_FOLLOW_ERR * 32'h00000004;
  localparam logic [31:0] ADDR_CONTROL = 32'h00000000;
  localparam logic [31:0] ADDR_STATUS = 32'h00000004;
  localparam logic [31:0] ADDR_TARGET = 32'h00000008;
  localparam logic [31:0] ADDR_RANGE_MIN = 32'h0000000C;
  localparam logic [31:0] ADDR_RANGE_MAX = 32'h00000010;
  localparam logic [31:0] ADDR_PLAN_TARGET = 32'h00000014;
  localparam logic [31:0] ADDR_PLAN_FLAGS = 32'h00000018;

  localparam logic [15:0] OPTIONS_RESET = 16'h0001;
  localparam logic [31:0] FOLLOW_ERR_RESET = 32'h00000000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [31:0] TARGET_RESET = 32'h00000000;
  localparam logic [31:0] RANGE_MIN_RESET = 32'h00000000;
  localparam logic [31:0] RANGE_MAX_RESET = 32'h00000167;

  localparam int REL_BASE_LSB = 0;
  localparam int RELEASE_LSB = 4;
  localparam int ROTARY_LSB = 6;
  localparam int CTRL_NEW_SETPOINT = 4;
  localparam int CTRL_RELATIVE = 6;
  localparam int STAT_SETPOINT_ACK = 12;

  localparam logic [1:0] BASE_PREV_TARGET = 2'h0;
  localparam logic [1:0] BASE_RAMP = 2'h1;
  localparam logic [1:0] BASE_ACTUAL = 2'h2;
  localparam logic [1:0] REL_HOST = 2'h0;
  localparam logic [1:0] REL_ON_REACH = 2'h1;
  localparam logic [1:0] REL_AT_ONCE = 2'h2;
  localparam logic [1:0] ROT_LINEAR = 2'h0;
  localparam logic [1:0] ROT_NEG_ONLY = 2'h1;
  localparam logic [1:0] ROT_POS_ONLY = 2'h2;
  localparam logic [1:0] ROT_SHORTEST = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] rotary;
    logic [1:0] release_sel;
    logic [1:0] base;
  } option_fields_t;

  typedef struct packed {
    logic [31:0] target;
    logic dir_positive;
    logic via_limit;
    logic wrapped;
  } move_plan_t;

  typedef struct packed {
    logic [31:0] ramp_output;
    logic [31:0] actual_position;
    logic [31:0] prev_target;
    logic has_prev_target;
  } position_inputs_t;

  function automatic option_fields_t decode_options(input logic [15:0] word);
    option_fields_t f;
    f.base = word[REL_BASE_LSB +: 2];
    f.release_sel = word[RELEASE_LSB +: 2];
    f.rotary = word[ROTARY_LSB +: 2];
    return f;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* File: core/move_planner.sv */
// Purpose: Works out the absolute target and travel direction of a new setpoint.
// Assumes: Positions are signed 32-bit values; range max is above range min.
// Notes: Purely combinational; the caller registers the result.
module move_planner (
  // Request
  input wire logic [31:0] target_in,
  input wire logic relative,
  input wire posopt_pkg::option_fields_t opts,
  input wire posopt_pkg::position_inputs_t pos,
  input wire logic [31:0] range_min,
  input wire logic [31:0] range_max,
  // Result
  output posopt_pkg::move_plan_t plan
);

  logic signed [31:0] base;
  logic signed [31:0] abs_t;
  logic signed [31:0] span;
  logic signed [31:0] diff;
  logic signed [31:0] act;

  always_comb begin
    base = '0;
    diff = '0;
    unique case (opts.base)
      posopt_pkg::BASE_RAMP: base = pos.ramp_output;
      posopt_pkg::BASE_ACTUAL: base = pos.actual_position;
      default: base = pos.has_prev_target ? pos.prev_target : 32'h00000000;
    endcase
    abs_t = relative ? base + $signed(target_in) : $signed(target_in);
    span = $signed(range_max) - $signed(range_min) + 32'sh00000001;
    act = $signed(pos.actual_position);
    plan = '0;
    plan.target = abs_t;
    unique case (opts.rotary)
      posopt_pkg::ROT_NEG_ONLY: begin
        plan.dir_positive = 1'b0;
        plan.via_limit = abs_t > act;
      end
      posopt_pkg::ROT_POS_ONLY: begin
        plan.dir_positive = 1'b1;
        plan.via_limit = abs_t < act;
      end
      posopt_pkg::ROT_SHORTEST: begin
        diff = (abs_t - act) % span;
        if (diff < 0) begin
          diff = diff + span;
        end
        plan.dir_positive = (diff <<< 1) < span;
        plan.via_limit = plan.dir_positive ? abs_t < act : abs_t > act;
      end
      default: begin
        plan.dir_positive = abs_t >= act;
        if (abs_t > $signed(range_max)) begin
          plan.target = abs_t - span;
          plan.wrapped = 1'b1;
        end else if (abs_t < $signed(range_min)) begin
          plan.target = abs_t + span;
          plan.wrapped = 1'b1;
        end
      end
    endcase
  end

endmodule

/* File: verif/axi_host.sv */
// Purpose: Host model that reaches the option registers over AXI4-Lite.
// Assumes: One write and one read at most under way; signals change just after a rising edge.
// Notes: Waits have no limit here; the bench timeout ends a hang.
module axi_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, wstrb, araddr} = '0;
  end

  // Offers address and data together and releases each once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask

  // Holds the read address until taken, then waits for the data.
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask
endmodule

/* File: verif/testbench.sv */
// Purpose: Self-checking bench of the positioning option decoder.
// Assumes: Ramp and actual position stay fixed; range limits keep their reset values.
// Notes: A monitor compares read data, write responses and move plans against queues filled by the driver.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, fe;
  logic [31:0] ramp_output = 32'h00000064;
  logic [31:0] actual_position = 32'h00000032;
  logic [31:0] following_error_in = 32'h00000000;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, move_start, setpoint_ack;
  logic profile_position_mode = 1'b1;
  logic target_reached = 1'b0;
  posopt_pkg::move_plan_t move_plan;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [34:0] pq[$];
  logic [34:0] mq[$];
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [15:0] t_opt[10] = '{16'h0020, 16'h00E1, 16'h00E2, 16'h0020, 16'h0022, 16'h00A0, 16'h0060, 16'h00E0,
                            16'h00E0, 16'h0020};
  logic [7:0] t_ctl[10] = '{8'h50, 8'h50, 8'h50, 8'h50, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h50};
  logic [15:0] t_tgt[10] = '{16'h0014, 16'h0014, 16'h0014, 16'h0014, 16'h00C8, 16'h001E, 16'h012C, 16'h0064,
                            16'h012C, 16'h0064};
  logic [15:0] t_exp[10] = '{16'h0014, 16'h0078, 16'h0046, 16'h005A, 16'h00C8, 16'h001E, 16'h012C, 16'h0064,
                            16'h012C, 16'h0028};
  logic [2:0] t_flg[10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h2, 3'h4, 3'h0, 3'h1};
  logic [2:0] t_msk[10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h6, 3'h4, 3'h4, 3'h1};

  always #4 aclk = ~aclk;

  positioning_option_decoder i_positioning_option_decoder (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .profile_position_mode(profile_position_mode), .target_reached(target_reached),
    .ramp_output(ramp_output), .actual_position(actual_position), .following_error_in(following_error_in),
    .move_start(move_start), .move_plan(move_plan), .setpoint_ack(setpoint_ack)
  );

  axi_host host (
    .aclk(aclk), .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .rvalid(s_axi_rvalid), .rready(s_axi_rready)
  );

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    host.wr(a, d);
  endtask

  task automatic rreg(input logic [31:0] a, input logic [33:0] e);
    rq.push_back(e);
    host.rd(a);
  endtask

  task automatic wait_ack(input logic v);
    int n;
    n = 0;
    while (setpoint_ack !== v && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk("setpoint_ack", {63'h0, v}, {63'h0, setpoint_ack});
  endtask

  // Takes the oldest expected value whenever a result shows at the ports.
  always @(posedge aclk) begin
    logic [34:0] m;
    m = 35'h7FFFFFFFF;
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      chk("rdata", rq.size() ? rq.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
    end
    if (aresetn && s_axi_bvalid && s_axi_bready) chk("bresp", bq.size() ? bq.pop_front() : 'x, s_axi_bresp);
    if (aresetn && move_start) begin
      if (mq.size()) m = mq.pop_front();
      chk("move_plan", pq.size() ? (pq.pop_front() & m) : 'x, move_plan & m);
    end
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(32'hD46AA33F));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rreg(posopt_pkg::ADDR_OPTIONS, {posopt_pkg::RESP_OKAY, 16'h0000, posopt_pkg::OPTIONS_RESET});
    fe = $urandom;
    following_error_in <= fe;
    rreg(posopt_pkg::ADDR_FOLLOW_ERR, {posopt_pkg::RESP_OKAY, fe});
    wreg(posopt_pkg::ADDR_FOLLOW_ERR, ~fe, posopt_pkg::RESP_SLVERR);
    rreg(32'h00000100, {posopt_pkg::RESP_SLVERR, 32'h00000000});
    fe = $urandom & 32'h00008F0C;
    wreg(posopt_pkg::ADDR_OPTIONS, fe, posopt_pkg::RESP_OKAY);
    rreg(posopt_pkg::ADDR_OPTIONS, {posopt_pkg::RESP_OKAY, fe});
    profile_position_mode <= 1'b0;
    wreg(posopt_pkg::ADDR_OPTIONS, 32'h00000020, posopt_pkg::RESP_OKAY);
    wreg(posopt_pkg::ADDR_CONTROL, 32'h00000010, posopt_pkg::RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk("setpoint_ack", 64'h0, {63'h0, setpoint_ack});
    rreg(posopt_pkg::ADDR_CONTROL, {posopt_pkg::RESP_OKAY, 32'h00000010});
    wreg(posopt_pkg::ADDR_CONTROL, 32'h00000000, posopt_pkg::RESP_OKAY);
    profile_position_mode <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      pq.push_back({16'h0000, t_exp[i], t_flg[i]});
      mq.push_back({32'h0000FFFF, t_msk[i]});
      wreg(posopt_pkg::ADDR_OPTIONS, {16'h0000, t_opt[i]}, posopt_pkg::RESP_OKAY);
      wreg(posopt_pkg::ADDR_TARGET, {16'h0000, t_tgt[i]}, posopt_pkg::RESP_OKAY);
      wreg(posopt_pkg::ADDR_CONTROL, {24'h000000, t_ctl[i]}, posopt_pkg::RESP_OKAY);
      rreg(posopt_pkg::ADDR_CONTROL, {posopt_pkg::RESP_OKAY, 24'h000000, t_ctl[i] & 8'hEF});
      wait_ack(1'b0);
    end
    rreg(posopt_pkg::ADDR_PLAN_TARGET, {posopt_pkg::RESP_OKAY, 32'h00000028});
    pq.push_back(35'h0);
    mq.push_back(35'h0);
    wreg(posopt_pkg::ADDR_OPTIONS, 32'h00000010, posopt_pkg::RESP_OKAY);
    wreg(posopt_pkg::ADDR_CONTROL, 32'h00000010, posopt_pkg::RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk("setpoint_ack", 64'h1, {63'h0, setpoint_ack});
    rreg(posopt_pkg::ADDR_STATUS, {posopt_pkg::RESP_OKAY, 32'h00001000});
    rreg(posopt_pkg::ADDR_CONTROL, {posopt_pkg::RESP_OKAY, 32'h00000010});
    target_reached <= 1'b1;
    wait_ack(1'b0);
    rreg(posopt_pkg::ADDR_CONTROL, {posopt_pkg::RESP_OKAY, 32'h00000000});
    rreg(posopt_pkg::ADDR_STATUS, {posopt_pkg::RESP_OKAY, 32'h00000000});
    target_reached <= 1'b0;
    pq.push_back(35'h0);
    mq.push_back(35'h0);
    wreg(posopt_pkg::ADDR_OPTIONS, 32'h00000000, posopt_pkg::RESP_OKAY);
    wreg(posopt_pkg::ADDR_CONTROL, 32'h00000010, posopt_pkg::RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk("setpoint_ack", 64'h1, {63'h0, setpoint_ack});
    wreg(posopt_pkg::ADDR_CONTROL, 32'h00000000, posopt_pkg::RESP_OKAY);
    wait_ack(1'b0);
    repeat (4) @(posedge aclk);
    chk("pending", 64'h0, 64'(pq.size() + rq.size() + bq.size()));
    wrap_up();
  end
endmodule
